/* File: rtl/rtm_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef RTM_CFG_SVH
`define RTM_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RTM_OFF_NRT_HI 8'h0F
`define RTM_OFF_NRT_LO 8'h10
`define RTM_OFF_CTRL 8'h11
`define RTM_OFF_GPT_HI 8'h12
`define RTM_OFF_GPT_LO 8'h13
`define RTM_OFF_MASK_MAIN 8'h14
`define RTM_OFF_MASK_TIM 8'h15
`define RTM_OFF_MASK_ERR 8'h16
`define RTM_OFF_STAT_MAIN 8'h17
`define RTM_OFF_STAT_TIM 8'h18
`define RTM_OFF_STAT_ERR 8'h19

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTM_CTRL_TRIG_HI 7
`define RTM_CTRL_TRIG_LO 5
`define RTM_CTRL_NRT_PAY 1
`define RTM_CTRL_NRT_STEP 0
`define RTM_TIM_NRE_BIT 6
`define RTM_TIM_GPE_BIT 5

// ----------------------------------------
// Reset values and unused-bit masks
// ----------------------------------------
`define RTM_RST_BYTE 8'h00
`define RTM_CTRL_WMASK 8'hE3
`define RTM_MAIN_WMASK 8'hFC

// ----------------------------------------
// Timing counts in carrier periods
// ----------------------------------------
`define RTM_GPT_STEP_FC 8
`define RTM_NRT_STEP_SHORT_FC 64
`define RTM_NRT_STEP_LONG_FC 4096

`endif

/* File: rtl/rtm_pkg.sv */
// Types shared by the timer and interrupt mask block
package rtm_pkg;

    // Trigger source codes of the general purpose timer
    typedef enum logic [2:0] {
        RTM_TRIG_NONE = 3'h0,
        RTM_TRIG_RX_END = 3'h1,
        RTM_TRIG_RX_START = 3'h2,
        RTM_TRIG_NFC_TX_END = 3'h3
    } rtm_trig_t;

    // Single-cycle event pulses from the framing logic
    typedef struct packed {
        logic [5:0] main_src;  // Oscillator, water level, rx start, rx end, tx end, collision
        logic [5:0] tim_src;   // Command done, field on/off, coll. avoid, guard, bit rate
        logic [7:0] err_src;   // Crc, parity, soft/hard framing, wake-up sources
    } rtm_evt_t;

    // Command pulses from the command decoder
    typedef struct packed {
        logic set_default;
        logic start_gpt;
        logic start_nrt;
    } rtm_cmd_t;

endpackage

/* File: rtl/rtm_timer.sv */
// Timer configuration, timers and interrupt mask/status block
//
// Contract
// - Code 000: start general timer by command only
// - 001 starts at rx end, 010 at rx start
// - 011 starts at NFC tx end; expiry drops field
// - Control bit 1 selects payment-compliance no-response mode
// - Control bit 0: step 64/fc or 4096/fc
// - General timeout high byte 12h, low 13h
// - General timer counts in 8/fc steps
// - Main mask bits 7..2 suppress their sources
// - Timer mask bits 7,4..0 suppress their sources
// - Timer mask bit6 no-response, bit5 general timer
// - Error mask bits 7..4 suppress error sources
// - Error mask bits 3..0 suppress wake-up sources
// - Defaults load at reset and set-default command
// - Zero no-response timeout never starts; command restarts
// - No-response expiry raises no-response interrupt
//
// Our own choice: the address-and-strobe port.
`include "rtm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module rtm_timer #(
    parameter int TW = 16  // Timeout register width, two bytes
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic fc_tick_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire rtm_pkg::rtm_evt_t evt_i,
    input wire rtm_pkg::rtm_cmd_t cmd_i,
    input wire logic nfc_mode_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    output logic field_off_o,
    output logic gpt_run_o,
    output logic nrt_run_o,
    output logic nrt_pay_mode_o
);
    import rtm_pkg::*;

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    // Timeouts are split across exactly two byte registers
    if (TW != 16)
    begin : g_tw_check
        $error("rtm_timer: TW must be 16");
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [7:0] ctrl_ff;      // Trigger select, payment mode, step select
    logic [7:0] gpt_hi_ff;    // General timeout upper byte
    logic [7:0] gpt_lo_ff;    // General timeout lower byte
    logic [7:0] nrt_hi_ff;    // No-response timeout upper byte
    logic [7:0] nrt_lo_ff;    // No-response timeout lower byte
    logic [7:0] mask_main_ff; // Main interrupt mask
    logic [7:0] mask_tim_ff;  // Timer and field interrupt mask
    logic [7:0] mask_err_ff;  // Error and wake-up interrupt mask
    logic [7:0] stat_main_ff; // Sticky main status
    logic [7:0] stat_tim_ff;  // Sticky timer status
    logic [7:0] stat_err_ff;  // Sticky error status
    logic [7:0] rdata_ff;     // Read data, one cycle after strobe
    logic irq_ff;             // Registered interrupt request
    logic field_off_ff;       // Field switch-off pulse

    // ----------------------------------------
    // Timer state
    // ----------------------------------------
    logic gpt_run_ff;         // General timer running
    logic [2:0] gpt_pre_ff;   // Eight-carrier prescaler
    logic [TW-1:0] gpt_cnt_ff;// Remaining general steps
    logic gpt_nfc_ff;         // Started by NFC tx end trigger
    logic nrt_run_ff;         // No-response timer running
    logic [11:0] nrt_pre_ff;  // Step prescaler, up to 4096
    logic [TW-1:0] nrt_cnt_ff;// Remaining no-response steps

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    // Write selects, one per offset
    wire wr_ctrl = wr_i && (addr_i == `RTM_OFF_CTRL);
    wire wr_gpt_hi = wr_i && (addr_i == `RTM_OFF_GPT_HI);
    wire wr_gpt_lo = wr_i && (addr_i == `RTM_OFF_GPT_LO);
    wire wr_nrt_hi = wr_i && (addr_i == `RTM_OFF_NRT_HI);
    wire wr_nrt_lo = wr_i && (addr_i == `RTM_OFF_NRT_LO);
    wire wr_m_main = wr_i && (addr_i == `RTM_OFF_MASK_MAIN);
    wire wr_m_tim = wr_i && (addr_i == `RTM_OFF_MASK_TIM);
    wire wr_m_err = wr_i && (addr_i == `RTM_OFF_MASK_ERR);
    // Status offsets: write one to clear
    wire wr_s_main = wr_i && (addr_i == `RTM_OFF_STAT_MAIN);
    wire wr_s_tim = wr_i && (addr_i == `RTM_OFF_STAT_TIM);
    wire wr_s_err = wr_i && (addr_i == `RTM_OFF_STAT_ERR);
    // Acts as a reset while enabled
    wire dflt = cmd_i.set_default;

    // Unmapped offsets read as zero
    // Status reads leave bits set
    wire [7:0] rd_mux =
        (addr_i == `RTM_OFF_NRT_HI) ? nrt_hi_ff :
        (addr_i == `RTM_OFF_NRT_LO) ? nrt_lo_ff :
        (addr_i == `RTM_OFF_CTRL) ? ctrl_ff :
        (addr_i == `RTM_OFF_GPT_HI) ? gpt_hi_ff :
        (addr_i == `RTM_OFF_GPT_LO) ? gpt_lo_ff :
        (addr_i == `RTM_OFF_MASK_MAIN) ? mask_main_ff :
        (addr_i == `RTM_OFF_MASK_TIM) ? mask_tim_ff :
        (addr_i == `RTM_OFF_MASK_ERR) ? mask_err_ff :
        (addr_i == `RTM_OFF_STAT_MAIN) ? stat_main_ff :
        (addr_i == `RTM_OFF_STAT_TIM) ? stat_tim_ff :
        (addr_i == `RTM_OFF_STAT_ERR) ? stat_err_ff :
        `RTM_RST_BYTE;

    // ----------------------------------------
    // Control field decode
    // ----------------------------------------
    // Trigger select, top three bits
    wire [2:0] trig_code = ctrl_ff[`RTM_CTRL_TRIG_HI:`RTM_CTRL_TRIG_LO];
    wire nrt_pay = ctrl_ff[`RTM_CTRL_NRT_PAY];
    wire nrt_long = ctrl_ff[`RTM_CTRL_NRT_STEP];
    wire [TW-1:0] gpt_val = {gpt_hi_ff, gpt_lo_ff};
    wire [TW-1:0] nrt_val = {nrt_hi_ff, nrt_lo_ff};

    // Frame events picked from the main event group
    wire ev_rxs = evt_i.main_src[3];
    wire ev_rxe = evt_i.main_src[2];
    wire ev_txe = evt_i.main_src[1];
    // Other main sources feed status only

    // Reserved codes fall through to no automatic trigger
    wire gpt_trig =
        (trig_code == RTM_TRIG_RX_END) ? ev_rxe :
        (trig_code == RTM_TRIG_RX_START) ? ev_rxs :
        (trig_code == RTM_TRIG_NFC_TX_END) ? (ev_txe && nfc_mode_i) :
        1'b0;
    // Command start works for every code
    wire gpt_start = cmd_i.start_gpt || gpt_trig;

    // ----------------------------------------
    // General timer step and expiry
    // ----------------------------------------
    localparam logic [2:0] GPT_PRE_LAST = 3'(`RTM_GPT_STEP_FC - 1);
    wire gpt_step = gpt_run_ff && fc_tick_i && (gpt_pre_ff == GPT_PRE_LAST);
    // A start in the last step wins
    wire gpt_exp = gpt_step && (gpt_cnt_ff == TW'(1)) && !gpt_start;

    // ----------------------------------------
    // No-response timer step and expiry
    // ----------------------------------------
    localparam logic [11:0] NRT_PRE_SHORT = 12'(`RTM_NRT_STEP_SHORT_FC - 1);
    localparam logic [11:0] NRT_PRE_LONG = 12'(`RTM_NRT_STEP_LONG_FC - 1);
    // Compare value follows step select
    wire [11:0] nrt_pre_last = nrt_long ? NRT_PRE_LONG : NRT_PRE_SHORT;
    // A zero timeout leaves the timer idle
    wire nrt_start = (cmd_i.start_nrt || ev_txe) && (nrt_val != '0);
    // Payment mode keeps counting through a response so expiry still reports
    wire nrt_stop = ev_rxs && !nrt_pay;
    wire nrt_step = nrt_run_ff && fc_tick_i && (nrt_pre_ff == nrt_pre_last);
    // A restart in the last step wins
    wire nrt_exp = nrt_step && (nrt_cnt_ff == TW'(1)) && !nrt_start;

    // ----------------------------------------
    // Status set terms
    // ----------------------------------------
    // Main bits 1..0 have no source
    wire [7:0] set_main = {evt_i.main_src, 2'b00};
    // Expiries sit in bits 6 and 5
    wire [7:0] set_tim = {evt_i.tim_src[5], nrt_exp, gpt_exp, evt_i.tim_src[4:0]};
    // Error and wake-up map one to one
    wire [7:0] set_err = evt_i.err_src;

    // Set wins over a simultaneous write-one clear
    wire [7:0] nxt_stat_main = dflt ? `RTM_RST_BYTE :
        ((stat_main_ff & ~(wr_s_main ? wdata_i : 8'h00)) | set_main);
    wire [7:0] nxt_stat_tim = dflt ? `RTM_RST_BYTE :
        ((stat_tim_ff & ~(wr_s_tim ? wdata_i : 8'h00)) | set_tim);
    wire [7:0] nxt_stat_err = dflt ? `RTM_RST_BYTE :
        ((stat_err_ff & ~(wr_s_err ? wdata_i : 8'h00)) | set_err);

    // Masks of next cycle, so the request tracks writes with no extra lag
    wire [7:0] nxt_mask_main = dflt ? `RTM_RST_BYTE :
        (wr_m_main ? (wdata_i & `RTM_MAIN_WMASK) : mask_main_ff);
    wire [7:0] nxt_mask_tim = dflt ? `RTM_RST_BYTE : (wr_m_tim ? wdata_i : mask_tim_ff);
    wire [7:0] nxt_mask_err = dflt ? `RTM_RST_BYTE : (wr_m_err ? wdata_i : mask_err_ff);

    // A set mask bit hides its source from the request line
    wire nxt_irq = |(nxt_stat_main & ~nxt_mask_main)
        || |(nxt_stat_tim & ~nxt_mask_tim)
        || |(nxt_stat_err & ~nxt_mask_err);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Reset and set-default both load the zero defaults
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            ctrl_ff <= `RTM_RST_BYTE;
            gpt_hi_ff <= `RTM_RST_BYTE;
            gpt_lo_ff <= `RTM_RST_BYTE;
            nrt_hi_ff <= `RTM_RST_BYTE;
            nrt_lo_ff <= `RTM_RST_BYTE;
        end
        else if (ce_i)
        begin
            if (dflt)
            begin
                ctrl_ff <= `RTM_RST_BYTE;
                gpt_hi_ff <= `RTM_RST_BYTE;
                gpt_lo_ff <= `RTM_RST_BYTE;
                nrt_hi_ff <= `RTM_RST_BYTE;
                nrt_lo_ff <= `RTM_RST_BYTE;
            end
            else
            begin
                // Timeout bytes load unlatched
                // Unused control bits stay zero
                if (wr_ctrl) ctrl_ff <= wdata_i & `RTM_CTRL_WMASK;
                if (wr_gpt_hi) gpt_hi_ff <= wdata_i;
                if (wr_gpt_lo) gpt_lo_ff <= wdata_i;
                if (wr_nrt_hi) nrt_hi_ff <= wdata_i;
                if (wr_nrt_lo) nrt_lo_ff <= wdata_i;
            end
        end
    end

    // ----------------------------------------
    // Masks, status and request
    // ----------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mask_main_ff <= `RTM_RST_BYTE;
            mask_tim_ff <= `RTM_RST_BYTE;
            mask_err_ff <= `RTM_RST_BYTE;
            stat_main_ff <= `RTM_RST_BYTE;
            stat_tim_ff <= `RTM_RST_BYTE;
            stat_err_ff <= `RTM_RST_BYTE;
            irq_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            // Next terms hold default and writes
            mask_main_ff <= nxt_mask_main;
            mask_tim_ff <= nxt_mask_tim;
            mask_err_ff <= nxt_mask_err;
            stat_main_ff <= nxt_stat_main;
            stat_tim_ff <= nxt_stat_tim;
            stat_err_ff <= nxt_stat_err;
            // Registered to keep the pin clean
            irq_ff <= nxt_irq;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Data stands for the single cycle after the strobe
    // Zero between reads
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            rdata_ff <= `RTM_RST_BYTE;
        else if (ce_i)
            rdata_ff <= rd_i ? rd_mux : `RTM_RST_BYTE;
    end

    // ----------------------------------------
    // General purpose timer
    // ----------------------------------------
    // A start while running reloads; zero timeout never starts
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            gpt_run_ff <= 1'b0;
            gpt_pre_ff <= 3'h0;
            gpt_cnt_ff <= '0;
            gpt_nfc_ff <= 1'b0;
            field_off_ff <= 1'b0;
        end
        else if (ce_i)
        begin
            // Field drops one cycle after an NFC-triggered expiry
            field_off_ff <= gpt_exp && gpt_nfc_ff && !dflt;
            // Stop on set-default
            if (dflt)
            begin
                gpt_run_ff <= 1'b0;
                gpt_nfc_ff <= 1'b0;
            end
            else if (gpt_start)
            begin
                gpt_run_ff <= (gpt_val != '0);
                gpt_pre_ff <= 3'h0;
                gpt_cnt_ff <= gpt_val;
                gpt_nfc_ff <= gpt_trig && (trig_code == RTM_TRIG_NFC_TX_END);
            end
            // Prescaler wraps every eight ticks
            else if (gpt_run_ff && fc_tick_i)
            begin
                gpt_pre_ff <= gpt_pre_ff + 3'h1;
                if (gpt_step)
                begin
                    gpt_cnt_ff <= gpt_cnt_ff - TW'(1);
                    if (gpt_exp)
                        gpt_run_ff <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // No-response timer
    // ----------------------------------------
    // Start command or tx end restarts from the full value
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            nrt_run_ff <= 1'b0;
            nrt_pre_ff <= 12'h000;
            nrt_cnt_ff <= '0;
        end
        else if (ce_i)
        begin
            // Set-default stops the timer
            if (dflt)
                nrt_run_ff <= 1'b0;
            else if (nrt_start)
            begin
                nrt_run_ff <= 1'b1;
                nrt_pre_ff <= 12'h000;
                nrt_cnt_ff <= nrt_val;
            end
            // A response ends the wait, except in payment mode
            else if (nrt_stop)
                nrt_run_ff <= 1'b0;
            else if (nrt_run_ff && fc_tick_i)
            begin
                // Wrap at the selected step length
                nrt_pre_ff <= nrt_step ? 12'h000 : nrt_pre_ff + 12'h001;
                if (nrt_step)
                begin
                    nrt_cnt_ff <= nrt_cnt_ff - TW'(1);
                    if (nrt_exp)
                        nrt_run_ff <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Outputs are register bits only
    assign rdata_o = rdata_ff;
    assign irq_o = irq_ff;
    assign field_off_o = field_off_ff;
    assign gpt_run_o = gpt_run_ff;
    assign nrt_run_o = nrt_run_ff;
    assign nrt_pay_mode_o = ctrl_ff[`RTM_CTRL_NRT_PAY];

endmodule

`default_nettype wire

/* File: tb/rtm_timer_chk.sv */
// Port-level checker for the timer and interrupt mask block
`include "rtm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module rtm_timer_chk (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire rtm_pkg::rtm_evt_t evt_i,
    input wire rtm_pkg::rtm_cmd_t cmd_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_o,
    input wire logic field_off_o,
    input wire logic gpt_run_o,
    input wire logic nrt_run_o,
    input wire logic nrt_pay_mode_o
);
    import rtm_pkg::*;
    // ----------------------------------------
    // Shadow copies of control and masks
    // ----------------------------------------
    logic [7:0] ctl_ff, mmain_ff, mtim_ff, merr_ff;
    wire clr = rst_i || (ce_i && cmd_i.set_default);
    wire we = ce_i && wr_i;
    // Code 000 or reserved: command start only
    wire cmd_only = (ctl_ff[7:5] == 3'h0) || ctl_ff[7];
    wire nrt_go = cmd_i.start_nrt || evt_i.main_src[1];
    wire all_msk = (&mmain_ff[7:2]) && (&mtim_ff) && (&merr_ff);
    // Same next-cycle timing as the block's own registers
    always_ff @(posedge mclk_i)
    begin
        if (clr)
        begin
            ctl_ff <= 8'h00;
            mmain_ff <= 8'h00;
            mtim_ff <= 8'h00;
            merr_ff <= 8'h00;
        end
        else if (we)
        begin
            if (addr_i == `RTM_OFF_CTRL) ctl_ff <= wdata_i;
            if (addr_i == `RTM_OFF_MASK_MAIN) mmain_ff <= wdata_i;
            if (addr_i == `RTM_OFF_MASK_TIM) mtim_ff <= wdata_i;
            if (addr_i == `RTM_OFF_MASK_ERR) merr_ff <= wdata_i;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    ctl_read_a: assert property (
        ce_i && rd_i && addr_i == `RTM_OFF_CTRL |=> rdata_o == (ctl_ff & `RTM_CTRL_WMASK))
        else $error("control readback wrong");
    main_read_a: assert property (
        ce_i && rd_i && addr_i == `RTM_OFF_MASK_MAIN |=> rdata_o == {mmain_ff[7:2], 2'b00})
        else $error("main mask readback wrong");
    tim_read_a: assert property (
        ce_i && rd_i && addr_i == `RTM_OFF_MASK_TIM |=> rdata_o == mtim_ff)
        else $error("timer mask readback wrong");
    pay_mode_a: assert property (nrt_pay_mode_o == ctl_ff[1])
        else $error("payment mode output wrong");
    gpt_cmd_a: assert property (
        $rose(gpt_run_o) && $past(cmd_only) |-> $past(cmd_i.start_gpt))
        else $error("general timer started without command");
    field_off_a: assert property (field_off_o |-> $fell(gpt_run_o))
        else $error("field off without timer expiry");
    nrt_start_a: assert property ($rose(nrt_run_o) |-> $past(nrt_go))
        else $error("no-response timer started without cause");
    irq_mask_a: assert property (all_msk |-> !irq_o)
        else $error("request raised while all masked");
    dflt_load_a: assert property (
        ce_i && cmd_i.set_default |=> !irq_o && !gpt_run_o && !nrt_run_o && !nrt_pay_mode_o)
        else $error("defaults not loaded");
    // Main scenarios reached
    cov_gpt_c: cover property ($fell(gpt_run_o));
    cov_nrt_c: cover property ($fell(nrt_run_o));
    cov_foff_c: cover property (field_off_o);
endmodule
bind rtm_timer rtm_timer_chk i_chk (.mclk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .evt_i, .cmd_i, .rdata_o, .irq_o, .field_off_o, .gpt_run_o, .nrt_run_o, .nrt_pay_mode_o);
`default_nettype wire

/* File: tb/rtm_host.sv */
// Host register-port master model
`timescale 1ns/100ps
`default_nettype none
module rtm_host (
    input wire logic mclk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // One write; idle edge after so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
        @(posedge mclk_i);
    endtask
    // Read data taken at the edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge mclk_i);
        rd_o <= 1'b0;
        @(posedge mclk_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_rtm_timer.sv */
// Self-checking bench for the timer and interrupt mask block
`include "rtm_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_rtm_timer;
    import rtm_pkg::*;
    localparam rtm_cmd_t C_DEF = 3'b100;
    localparam rtm_cmd_t C_GPT = 3'b010;
    localparam rtm_cmd_t C_NRT = 3'b001;
    logic mclk, rst, ce, fc, nfc, wr, rd, irq, foff, grun, nrun, pay;
    logic [7:0] addr, wdata, rdata;
    rtm_evt_t evt;
    rtm_cmd_t cmd;
    int n_errors, n_checks;
    rtm_host u_host (.mclk_i(mclk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    rtm_timer i_dut (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .fc_tick_i(fc), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .evt_i(evt), .cmd_i(cmd), .nfc_mode_i(nfc),
        .rdata_o(rdata), .irq_o(irq), .field_off_o(foff), .gpt_run_o(grun),
        .nrt_run_o(nrun), .nrt_pay_mode_o(pay));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_host.rd(a, v);
        chk(v, exp);
    endtask
    // Carrier ticks spaced one idle cycle apart
    task automatic ticks(input int n);
        repeat (n)
        begin
            fc <= 1'b1;
            @(posedge mclk);
            fc <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task automatic pulse(input rtm_cmd_t c, input rtm_evt_t e);
        cmd <= c;
        evt <= e;
        @(posedge mclk);
        cmd <= '0;
        evt <= '0;
        @(posedge mclk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        for (int i = 'h11; i <= 'h16; i++)
            rchk(i[7:0], 8'h00);
        for (int i = 'h11; i <= 'h16; i++)
            u_host.wr(i[7:0], 8'hFF);
        rchk(`RTM_OFF_CTRL, 8'hE3);
        chk({7'h00, pay}, 8'h01);
        rchk(`RTM_OFF_GPT_HI, 8'hFF);
        rchk(`RTM_OFF_GPT_LO, 8'hFF);
        rchk(`RTM_OFF_MASK_MAIN, 8'hFC);
        rchk(`RTM_OFF_MASK_TIM, 8'hFF);
        rchk(`RTM_OFF_MASK_ERR, 8'hFF);
        u_host.wr(8'h20, 8'h5A);
        rchk(8'h20, 8'h00);
        pulse(C_DEF, '0);
        for (int i = 'h11; i <= 'h16; i++)
            rchk(i[7:0], 8'h00);
        chk({7'h00, pay}, 8'h00);
        $display("test regs done");
    endtask
    // Every code against every trigger event, then the command
    task automatic t_trig();
        rtm_evt_t e;
        logic hit;
        u_host.wr(`RTM_OFF_GPT_LO, 8'h01);
        for (int c = 0; c < 8; c++)
        begin
            u_host.wr(`RTM_OFF_CTRL, {c[2:0], 5'h00});
            for (int k = 1; k <= 3; k++)
            begin
                e = '0;
                e.main_src[k] = 1'b1;
                hit = (c == (k == 2 ? 1 : (k == 3 ? 2 : 3)));
                pulse(3'b000, e);
                chk({7'h00, grun}, {7'h00, hit});
                if (hit)
                begin
                    ticks(8);
                    chk({7'h00, foff}, {7'h00, c == 3});
                end
            end
            if (c == 3)
            begin
                nfc <= 1'b0;
                e = '0;
                e.main_src[1] = 1'b1;
                pulse(3'b000, e);
                chk({7'h00, grun}, 8'h00);
                nfc <= 1'b1;
            end
            pulse(C_GPT, '0);
            chk({7'h00, grun}, 8'h01);
            ticks(7);
            chk({7'h00, grun}, 8'h01);
            ticks(1);
            chk({7'h00, grun}, 8'h00);
        end
        $display("test trigger done");
    endtask
    task automatic t_gpt16();
        u_host.wr(`RTM_OFF_CTRL, 8'h00);
        for (int i = 'h17; i <= 'h19; i++)
            u_host.wr(i[7:0], 8'hFF);
        u_host.wr(`RTM_OFF_GPT_HI, 8'h01);
        u_host.wr(`RTM_OFF_GPT_LO, 8'h00);
        ce <= 1'b0;
        pulse(C_GPT, '0);
        chk({7'h00, grun}, 8'h00);
        ce <= 1'b1;
        pulse(C_GPT, '0);
        ticks(2047);
        chk({7'h00, grun}, 8'h01);
        ticks(1);
        chk({7'h00, grun}, 8'h00);
        rchk(`RTM_OFF_STAT_TIM, 8'h20);
        chk({7'h00, irq}, 8'h01);
        u_host.wr(`RTM_OFF_MASK_TIM, 8'h20);
        chk({7'h00, irq}, 8'h00);
        $display("test general timeout done");
    endtask
    task automatic t_nrt();
        rtm_evt_t e;
        pulse(C_DEF, '0);
        pulse(C_NRT, '0);
        chk({7'h00, nrun}, 8'h00);
        u_host.wr(`RTM_OFF_NRT_LO, 8'h01);
        pulse(C_NRT, '0);
        ticks(30);
        pulse(C_NRT, '0);
        ticks(63);
        chk({7'h00, nrun}, 8'h01);
        ticks(1);
        chk({7'h00, nrun}, 8'h00);
        rchk(`RTM_OFF_STAT_TIM, 8'h40);
        e = '0;
        e.main_src[3] = 1'b1;
        pulse(C_NRT, '0);
        pulse(3'b000, e);
        chk({7'h00, nrun}, 8'h00);
        u_host.wr(`RTM_OFF_CTRL, 8'h03);
        pulse(C_NRT, '0);
        pulse(3'b000, e);
        chk({7'h00, nrun}, 8'h01);
        ticks(4095);
        chk({7'h00, nrun}, 8'h01);
        ticks(1);
        chk({7'h00, nrun}, 8'h00);
        $display("test no-response done");
    endtask
    // One source unmasked at a time, then clear by writing ones
    task automatic t_irq();
        logic exp;
        pulse(C_DEF, '0);
        for (int r = 0; r < 3; r++)
            u_host.wr(8'h14 + r[7:0], 8'hFF);
        pulse(3'b000, '1);
        chk({7'h00, irq}, 8'h00);
        rchk(`RTM_OFF_STAT_MAIN, 8'hFC);
        rchk(`RTM_OFF_STAT_TIM, 8'h9F);
        rchk(`RTM_OFF_STAT_ERR, 8'hFF);
        for (int r = 0; r < 3; r++)
            for (int b = 0; b < 8; b++)
            begin
                exp = !((r == 0 && b < 2) || (r == 1 && (b == 5 || b == 6)));
                u_host.wr(8'h14 + r[7:0], ~(8'h01 << b));
                chk({7'h00, irq}, {7'h00, exp});
                u_host.wr(8'h14 + r[7:0], 8'hFF);
            end
        for (int r = 0; r < 3; r++)
            u_host.wr(8'h17 + r[7:0], 8'hFF);
        for (int r = 0; r < 3; r++)
            u_host.wr(8'h14 + r[7:0], 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("test interrupt done");
    endtask
    // ----------------------------------------
    // Clock, reset, sequence, watchdog
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        fc = 1'b0;
        nfc = 1'b1;
        evt = '0;
        cmd = '0;
        n_errors = 0;
        n_checks = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_trig();
        t_gpt16();
        t_nrt();
        t_irq();
        summarize();
    end
    // Hang guard well above the longest sequence
    initial
    begin
        repeat (80000) @(posedge mclk);
        n_errors++;
        $display("FAIL %0t run did not finish", $time);
        summarize();
    end
endmodule
`default_nettype wire
